// *** dv/atcs_osc_model.sv ***
// Behavioural crystal or external clock on the oscillator input pin
module atcs_osc_model #(
    parameter int HALF = 4
) (
    input wire logic hclk,
    input wire logic run,
    output logic osc_in_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    initial osc_in_pin = 1'b0;
    // Period of 2*HALF core cycles keeps the core over four times faster
    always @(posedge hclk) begin
        // Stands still while the device has the oscillator stopped
        if (run) begin
            if (n == HALF - 1) begin
                n <= 0;
                osc_in_pin <= !osc_in_pin;
            end else begin
                n <= n + 1;
            end
        end
    end
endmodule

// *** dv/atcs_timer_sync_checker.sv ***
// Port-level assertions for the async timer block
`include "atcs_regs.vh"
module atcs_timer_sync_checker (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire sleep_save,
    input wire sleep_deep,
    input wire osc_enable,
    input wire osc_drive_en,
    input wire pins_to_osc,
    input wire wake_req,
    input wire cpu_hold
);
    timeunit 1ns;
    timeprecision 1ps;
    wire stat_wr;
    assign stat_wr = hsel && htrans[1] && hready && hwrite &&
        haddr[7:0] == `ATCS_OFF_STAT;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus stalled or erred");
    a_osc_follow: assert property (
        osc_enable == (pins_to_osc && !sleep_deep))
        else $error("oscillator enable wrong");
    a_osc_drive: assert property (osc_drive_en |-> osc_enable)
        else $error("crystal driver on without oscillator");
    a_pins_cause: assert property (
        $changed(pins_to_osc) |-> $past(stat_wr, 2))
        else $error("pin takeover without status write");
    a_wake_pulse: assert property (wake_req |=> !wake_req)
        else $error("wake request longer than a cycle");
    a_wake_sleep: assert property (wake_req |-> $past(sleep_save))
        else $error("wake request outside sleep");
    a_hold_four: assert property (wake_req |=> cpu_hold [*4])
        else $error("processor hold too short");
    a_hold_end: assert property (
        $fell(cpu_hold) |-> $past(wake_req, 5))
        else $error("processor hold wrong length");
    a_read_upper: assert property (hrdata[31:8] == 24'h000000)
        else $error("upper read bits set");
endmodule
bind atcs_timer_sync atcs_timer_sync_checker u_atcs_timer_sync_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sleep_save(sleep_save), .sleep_deep(sleep_deep),
    .osc_enable(osc_enable), .osc_drive_en(osc_drive_en),
    .pins_to_osc(pins_to_osc), .wake_req(wake_req), .cpu_hold(cpu_hold)
);

// *** dv/atcs_timer_sync_tb_top.sv ***
// Self-checking bench for the async timer clocking block
`include "atcs_regs.vh"
module atcs_timer_sync_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STAB = 20;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic sleep_save = 1'b0;
    logic sleep_deep = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] r;
    logic [31:0] v;
    logic [7:0] v0;
    logic ext;
    logic oc0;
    logic signed [31:0] dv;
    wire hready, hreadyout, hresp, osc_in_pin, osc_enable, osc_drive_en;
    wire pins_to_osc, compare_out, timer_irq, wake_req, cpu_hold;
    wire [31:0] hrdata;
    int errors = 0;
    int num_checks = 0;
    int seed = 28135;
    int cyc = 0;
    int k, n, c0, ex, tol;
    int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    always #5 hclk = !hclk;
    always @(posedge hclk) cyc <= cyc + 1;
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    atcs_timer_sync #(.STABLE_CYC(STAB)) u_atcs_timer_sync (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .osc_in_pin(osc_in_pin),
        .sleep_save(sleep_save), .sleep_deep(sleep_deep),
        .osc_enable(osc_enable), .osc_drive_en(osc_drive_en),
        .pins_to_osc(pins_to_osc), .compare_out(compare_out),
        .timer_irq(timer_irq), .wake_req(wake_req), .cpu_hold(cpu_hold)
    );
    atcs_osc_model u_atcs_osc_model (
        .hclk(hclk), .run(osc_enable), .osc_in_pin(osc_in_pin)
    );
    task stop_test;
        $display("errors=%0d checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wait_rdy;
        int m;
        m = 0;
        do begin
            @(posedge hclk);
            m++;
        end while (hready !== 1'b1 && m < 50);
        if (hready !== 1'b1) begin
            errors++;
            stop_test;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    // Polls a busy flag; the bound stands in for a stuck transfer
    task idle(input int b);
        int m;
        m = 0;
        do begin
            rd(`ATCS_OFF_STAT);
            m++;
        end while (r[b] !== 1'b0 && m < 200);
        if (r[b] !== 1'b0) begin
            errors++;
            stop_test;
        end
    endtask
    initial begin
        repeat (100000) @(posedge hclk);
        errors++;
        stop_test;
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (STAB + 5) @(posedge hclk);
        rd(`ATCS_OFF_STAT);
        check(r, 32'h40);
        rd(8'h18);
        check(r, 32'h0);
        // Every clock select code, measured against core cycles
        for (k = 0; k < 8; k++) begin
            wr(`ATCS_OFF_CTRL, k);
            wr(`ATCS_OFF_GTC, 32'h2);
            idle(0);
            rd(`ATCS_OFF_COUNT);
            c0 = cyc;
            v0 = r[7:0];
            repeat (16 * (divs[k] + 1)) @(posedge hclk);
            rd(`ATCS_OFF_COUNT);
            ex = (k == 0) ? 0 : (cyc - c0) / divs[k];
            tol = (k == 0) ? 0 : 1;
            dv = {24'h000000, r[7:0] - v0} - ex;
            check(dv <= tol && dv >= -tol, 32'h1);
        end
        wr(`ATCS_OFF_CTRL, 32'h0);
        idle(0);
        ext = $random(seed) & 1;
        wr(`ATCS_OFF_STAT, {27'h0, ext, 4'h8});
        repeat (2) @(posedge hclk);
        check(pins_to_osc, 1'b1);
        check(osc_drive_en, !ext);
        v = $random(seed);
        wr(`ATCS_OFF_COUNT, v[7:0]);
        // Upper-half compare keeps a match away from the flag clear
        wr(`ATCS_OFF_CMP, {24'h000000, 1'b1, v[14:8]});
        rd(`ATCS_OFF_STAT);
        check(r[2:1], 2'h3);
        idle(2);
        idle(1);
        // Counter copy refreshes on the next oscillator edges
        repeat (16) @(posedge hclk);
        rd(`ATCS_OFF_COUNT);
        check(r[7:0], v[7:0]);
        rd(`ATCS_OFF_CMP);
        check(r[7:0], {1'b1, v[14:8]});
        sleep_deep <= 1'b1;
        repeat (2) @(posedge hclk);
        check(osc_enable, 1'b0);
        sleep_deep <= 1'b0;
        rd(`ATCS_OFF_STAT);
        check(r[5], 1'b1);
        wr(`ATCS_OFF_COUNT, 32'h0);
        idle(2);
        rd(`ATCS_OFF_STAT);
        check(r[5], 1'b0);
        // Overflow wakes the core from power-save
        wr(`ATCS_OFF_CTRL, 32'h1);
        idle(0);
        wr(`ATCS_OFF_FLAG, 32'h10);
        sleep_save <= 1'b1;
        n = 0;
        while (wake_req !== 1'b1 && n < 3000) begin
            @(posedge hclk);
            n++;
        end
        check(wake_req, 1'b1);
        sleep_save <= 1'b0;
        check(timer_irq, 1'b1);
        @(posedge hclk);
        check(cpu_hold, 1'b1);
        // Both flags cleared: compare matched while counting up
        wr(`ATCS_OFF_FLAG, 32'h3);
        rd(`ATCS_OFF_FLAG);
        check(r[5:0], 6'h0);
        check(timer_irq, 1'b0);
        wr(`ATCS_OFF_CMP, 32'h80);
        idle(1);
        rd(`ATCS_OFF_COUNT);
        check(r[7:0] != 8'h00 && r[7] == 1'b0, 32'h1);
        wr(`ATCS_OFF_CTRL, 32'h11);
        idle(0);
        // Count reloaded one below compare; the compare rewrite then
        // stays pending over the matching tick, so the pin must hold
        oc0 = compare_out;
        wr(`ATCS_OFF_COUNT, 32'h7F);
        idle(2);
        wr(`ATCS_OFF_CMP, 32'h80);
        idle(1);
        check(compare_out, oc0);
        n = 0;
        while (compare_out === oc0 && n < 2200) begin
            @(posedge hclk);
            n++;
        end
        check(compare_out, !oc0);
        repeat (8) @(posedge hclk);
        stop_test;
    end
endmodule

// *** shared/atcs_regs.vh ***
// Register map, field positions and timing constants of the async timer
`ifndef ATCS_REGS_VH
`define ATCS_REGS_VH
`define ATCS_OFF_CTRL 8'h00
`define ATCS_OFF_COUNT 8'h04
`define ATCS_OFF_CMP 8'h08
`define ATCS_OFF_STAT 8'h0C
`define ATCS_OFF_GTC 8'h10
`define ATCS_OFF_FLAG 8'h14
`define ATCS_ADDR_W 8
`define ATCS_NREG 3
`define ATCS_IX_CTRL 0
`define ATCS_IX_CMP 1
`define ATCS_IX_COUNT 2
`define ATCS_CS_LSB 0
`define ATCS_CS_MSB 2
`define ATCS_COM_LSB 4
`define ATCS_COM_MSB 5
`define ATCS_ST_EXT 4
`define ATCS_ST_ASYNC 3
`define ATCS_ST_LOST 5
`define ATCS_ST_READY 6
`define ATCS_GTC_PSR 1
`define ATCS_FL_OVF 0
`define ATCS_FL_CMP 1
`define ATCS_EN_OVF 4
`define ATCS_EN_CMP 5
`define ATCS_RST8 8'h00
`define ATCS_CNT_MAX 8'hFF
`define ATCS_SYNC_EDGES 2'h2
`define ATCS_FLAG_STAGES 3
`define ATCS_HOLD_CYC 3'h4
`define ATCS_CLK_HZ 100000000
`define ATCS_STABLE_MS 1000
`define ATCS_MS_PER_S 1000
`define ATCS_CS_STOP 3'h0
`define ATCS_CS_DIV1 3'h1
`define ATCS_CS_DIV8 3'h2
`define ATCS_CS_DIV32 3'h3
`define ATCS_CS_DIV64 3'h4
`define ATCS_CS_DIV128 3'h5
`define ATCS_CS_DIV256 3'h6
`define ATCS_CS_DIV1024 3'h7
`define ATCS_COM_OFF 2'h0
`define ATCS_COM_TGL 2'h1
`define ATCS_COM_CLR 2'h2
`define ATCS_COM_SET 2'h3
`endif

// *** verilog/atcs_hold.v ***
// Holding register that carries one software write into the timer domain
`include "atcs_regs.vh"
module atcs_hold #(
    parameter W = 8
) (
    input wire hclk,
    input wire hresetn,
    input wire wr_en,
    input wire [W-1:0] wr_data,
    input wire src_tick,
    output wire busy,
    output wire load,
    output wire [W-1:0] hold_data
);
    reg busy_ff;
    reg [1:0] edge_ff;
    reg [W-1:0] data_ff;
    reg nxt_busy;
    reg [1:0] nxt_edge;
    wire last_edge;

    assign last_edge = (edge_ff == `ATCS_SYNC_EDGES - 2'h1);
    assign load = busy_ff & src_tick & last_edge & ~wr_en;
    assign busy = busy_ff;
    assign hold_data = data_ff;

    always @* begin
        nxt_busy = busy_ff;
        nxt_edge = edge_ff;
        if (wr_en) begin
            // New write restarts the transfer; the set wins over clear
            nxt_busy = 1'b1;
            nxt_edge = 2'h0;
        end else if (busy_ff & src_tick) begin
            if (last_edge) begin
                nxt_busy = 1'b0;
                nxt_edge = 2'h0;
            end else begin
                nxt_edge = edge_ff + 2'h1;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_ff <= 1'b0;
            edge_ff <= 2'h0;
            data_ff <= {W{1'b0}};
        end else begin
            busy_ff <= nxt_busy;
            edge_ff <= nxt_edge;
            if (wr_en) begin
                data_ff <= wr_data;
            end
        end
    end
endmodule

// *** verilog/atcs_timer_sync.v ***
// Async timer clocking, prescaler, register crossing and wake-up logic
`include "atcs_regs.vh"
module atcs_timer_sync #(
    parameter STABLE_CYC = `ATCS_CLK_HZ / `ATCS_MS_PER_S * `ATCS_STABLE_MS,
    parameter PRE_W = 10
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    input wire osc_in_pin,
    input wire sleep_save,
    input wire sleep_deep,
    output wire osc_enable,
    output wire osc_drive_en,
    output wire pins_to_osc,
    output wire compare_out,
    output wire timer_irq,
    output wire wake_req,
    output wire cpu_hold
);
    reg wr_ff;
    reg [`ATCS_ADDR_W-1:0] addr_ff;
    reg [31:0] rdata_ff;
    reg [7:0] ctrl_ff;
    reg [7:0] count_ff;
    reg [7:0] cmp_ff;
    reg [7:0] count_rd_ff;
    reg async_ff;
    reg ext_ff;
    reg lost_ff;
    reg [26:0] stable_ff;
    reg ready_ff;
    reg deep_d_ff;
    reg osc_d_ff;
    reg [PRE_W-1:0] pre_ff;
    reg oc_ff;
    reg [1:0] flag_ff;
    reg [1:0] en_ff;
    reg [`ATCS_FLAG_STAGES-1:0] ovf_pipe_ff;
    reg [`ATCS_FLAG_STAGES-1:0] cmp_pipe_ff;
    reg arm_ff;
    reg wake_pend_ff;
    reg wake_ff;
    reg [2:0] hold_ff;
    reg cnt_tick;
    reg [31:0] nxt_rdata;
    reg [7:0] nxt_count;
    reg nxt_oc;
    wire take;
    wire wr_now;
    wire src_tick;
    wire cmp_block;
    wire cmp_evt;
    wire ovf_evt;
    wire [2:0] cs;
    wire [1:0] com;
    wire deep_exit;
    wire irq_cond;
    wire [`ATCS_NREG-1:0] wr_vec;
    wire [`ATCS_NREG-1:0] busy_vec;
    wire [`ATCS_NREG-1:0] load_vec;
    wire [8*`ATCS_NREG-1:0] hold_vec;

    // Bus slave: zero wait states, always OKAY
    assign take = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;
    assign wr_now = wr_ff;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            addr_ff <= `ATCS_RST8;
        end else if (hready) begin
            wr_ff <= take & hwrite;
            addr_ff <= haddr[`ATCS_ADDR_W-1:0];
        end
    end

    assign wr_vec[`ATCS_IX_CTRL] = wr_now & (addr_ff == `ATCS_OFF_CTRL);
    assign wr_vec[`ATCS_IX_CMP] = wr_now & (addr_ff == `ATCS_OFF_CMP);
    assign wr_vec[`ATCS_IX_COUNT] = wr_now & (addr_ff == `ATCS_OFF_COUNT);

    // One holding register per synchronised register
    genvar gi;
    generate
        for (gi = 0; gi < `ATCS_NREG; gi = gi + 1) begin : g_hold
            atcs_hold #(
                .W(8)
            ) u_hold (
                .hclk(hclk),
                .hresetn(hresetn),
                .wr_en(wr_vec[gi]),
                .wr_data(hwdata[7:0]),
                .src_tick(src_tick),
                .busy(busy_vec[gi]),
                .load(load_vec[gi]),
                .hold_data(hold_vec[8*gi +: 8])
            );
        end
    endgenerate

    // Read data is registered in the address phase
    always @* begin
        nxt_rdata = 32'h00000000;
        case (haddr[`ATCS_ADDR_W-1:0])
            `ATCS_OFF_CTRL: nxt_rdata[7:0] = ctrl_ff;
            `ATCS_OFF_COUNT: nxt_rdata[7:0] = count_rd_ff;
            `ATCS_OFF_CMP: nxt_rdata[7:0] = cmp_ff;
            `ATCS_OFF_STAT: begin
                nxt_rdata[2:0] = busy_vec;
                nxt_rdata[`ATCS_ST_ASYNC] = async_ff;
                nxt_rdata[`ATCS_ST_EXT] = ext_ff;
                nxt_rdata[`ATCS_ST_LOST] = lost_ff;
                nxt_rdata[`ATCS_ST_READY] = ready_ff;
            end
            `ATCS_OFF_FLAG: begin
                nxt_rdata[`ATCS_FL_OVF] = flag_ff[0];
                nxt_rdata[`ATCS_FL_CMP] = flag_ff[1];
                nxt_rdata[`ATCS_EN_OVF] = en_ff[0];
                nxt_rdata[`ATCS_EN_CMP] = en_ff[1];
            end
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h00000000;
        end else if (take & ~hwrite) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Status register: source select and external clock enable
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            async_ff <= 1'b0;
            ext_ff <= 1'b0;
        end else if (wr_now & (addr_ff == `ATCS_OFF_STAT)) begin
            // Pending transfers are not protected across a switch
            async_ff <= hwdata[`ATCS_ST_ASYNC];
            ext_ff <= hwdata[`ATCS_ST_EXT];
        end
    end

    assign pins_to_osc = async_ff;
    assign osc_enable = async_ff & ~sleep_deep;
    assign osc_drive_en = osc_enable & ~ext_ff;

    // Oscillator pin is sampled directly; it must be far slower than hclk
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_d_ff <= 1'b0;
        end else begin
            osc_d_ff <= osc_in_pin;
        end
    end

    // Source tick: every cycle when synchronous, rising osc edge otherwise; none while sleep_deep is high
    assign src_tick = async_ff ? (osc_in_pin & ~osc_d_ff & ~sleep_deep)
                               : ~sleep_deep;

    // Oscillator settle time and lost-contents marker
    assign deep_exit = deep_d_ff & ~sleep_deep;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            deep_d_ff <= 1'b0;
            stable_ff <= 27'h0000000;
            ready_ff <= 1'b0;
            lost_ff <= 1'b0;
        end else begin
            deep_d_ff <= sleep_deep;
            if (deep_exit | sleep_deep) begin
                stable_ff <= 27'h0000000;
                ready_ff <= 1'b0;
            end else if (stable_ff == STABLE_CYC[26:0] - 27'h1) begin
                ready_ff <= 1'b1;
            end else if (!ready_ff) begin
                stable_ff <= stable_ff + 27'h1;
            end
            if (deep_exit) begin
                lost_ff <= 1'b1;
            end else if (wr_vec[`ATCS_IX_COUNT]) begin
                lost_ff <= 1'b0;
            end
        end
    end

    // Prescaler with software reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_ff <= {PRE_W{1'b0}};
        end else if (wr_now & (addr_ff == `ATCS_OFF_GTC)
                     & hwdata[`ATCS_GTC_PSR]) begin
            pre_ff <= {PRE_W{1'b0}};
        end else if (src_tick) begin
            pre_ff <= pre_ff + {{(PRE_W-1){1'b0}}, 1'b1};
        end
    end

    assign cs = ctrl_ff[`ATCS_CS_MSB:`ATCS_CS_LSB];
    assign com = ctrl_ff[`ATCS_COM_MSB:`ATCS_COM_LSB];

    always @* begin
        case (cs)
            `ATCS_CS_STOP: cnt_tick = 1'b0;
            `ATCS_CS_DIV1: cnt_tick = src_tick;
            `ATCS_CS_DIV8: cnt_tick = src_tick & (&pre_ff[2:0]);
            `ATCS_CS_DIV32: cnt_tick = src_tick & (&pre_ff[4:0]);
            `ATCS_CS_DIV64: cnt_tick = src_tick & (&pre_ff[5:0]);
            `ATCS_CS_DIV128: cnt_tick = src_tick & (&pre_ff[6:0]);
            `ATCS_CS_DIV256: cnt_tick = src_tick & (&pre_ff[7:0]);
            `ATCS_CS_DIV1024: cnt_tick = src_tick & (&pre_ff[9:0]);
            default: cnt_tick = 1'b0;
        endcase
    end

    // Timer-domain registers take the holding values on transfer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= `ATCS_RST8;
            cmp_ff <= `ATCS_RST8;
        end else begin
            if (load_vec[`ATCS_IX_CTRL]) begin
                ctrl_ff <= hold_vec[8*`ATCS_IX_CTRL +: 8];
            end
            if (load_vec[`ATCS_IX_CMP]) begin
                cmp_ff <= hold_vec[8*`ATCS_IX_CMP +: 8];
            end
        end
    end

    always @* begin
        nxt_count = count_ff;
        if (load_vec[`ATCS_IX_COUNT]) begin
            nxt_count = hold_vec[8*`ATCS_IX_COUNT +: 8];
        end else if (cnt_tick) begin
            nxt_count = count_ff + 8'h01;
        end
    end

    // Compare is gated while a count or compare transfer is pending
    assign cmp_block = busy_vec[`ATCS_IX_CMP] | busy_vec[`ATCS_IX_COUNT];
    assign cmp_evt = cnt_tick & (count_ff == cmp_ff) & ~cmp_block;
    assign ovf_evt = cnt_tick & (count_ff == `ATCS_CNT_MAX);

    always @* begin
        nxt_oc = oc_ff;
        if (cmp_evt) begin
            case (com)
                `ATCS_COM_TGL: nxt_oc = ~oc_ff;
                `ATCS_COM_CLR: nxt_oc = 1'b0;
                `ATCS_COM_SET: nxt_oc = 1'b1;
                default: nxt_oc = oc_ff;
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_ff <= `ATCS_RST8;
            count_rd_ff <= `ATCS_RST8;
            oc_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            oc_ff <= nxt_oc;
            if (src_tick) begin
                count_rd_ff <= count_ff;
            end
        end
    end

    assign compare_out = oc_ff;

    // Flag events cross by a fixed three-cycle pipeline
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_pipe_ff <= {`ATCS_FLAG_STAGES{1'b0}};
            cmp_pipe_ff <= {`ATCS_FLAG_STAGES{1'b0}};
        end else begin
            ovf_pipe_ff <= {ovf_pipe_ff[`ATCS_FLAG_STAGES-2:0], ovf_evt};
            cmp_pipe_ff <= {cmp_pipe_ff[`ATCS_FLAG_STAGES-2:0], cmp_evt};
        end
    end

    // Flags are write-one-to-clear; a new event wins over the clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_ff <= 2'h0;
            en_ff <= 2'h0;
        end else begin
            if (wr_now & (addr_ff == `ATCS_OFF_FLAG)) begin
                en_ff <= {hwdata[`ATCS_EN_CMP], hwdata[`ATCS_EN_OVF]};
                flag_ff <= (flag_ff & ~{hwdata[`ATCS_FL_CMP],
                           hwdata[`ATCS_FL_OVF]})
                           | {cmp_pipe_ff[`ATCS_FLAG_STAGES-1],
                           ovf_pipe_ff[`ATCS_FLAG_STAGES-1]};
            end else begin
                flag_ff <= flag_ff | {cmp_pipe_ff[`ATCS_FLAG_STAGES-1],
                           ovf_pipe_ff[`ATCS_FLAG_STAGES-1]};
            end
        end
    end

    assign timer_irq = |(flag_ff & en_ff);

    // Wake from power-save: condition seen, wake on the next timer cycle
    assign irq_cond = (cmp_evt & en_ff[1]) | (ovf_evt & en_ff[0]);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arm_ff <= 1'b1;
            wake_pend_ff <= 1'b0;
            wake_ff <= 1'b0;
            hold_ff <= 3'h0;
        end else begin
            wake_ff <= 1'b0;
            if (sleep_save & arm_ff & irq_cond) begin
                wake_pend_ff <= 1'b1;
            end else if (wake_pend_ff & src_tick) begin
                wake_pend_ff <= 1'b0;
                wake_ff <= 1'b1;
            end
            // Interrupt logic re-arms only after one timer cycle
            if (wake_ff) begin
                arm_ff <= 1'b0;
            end else if (src_tick & ~sleep_save) begin
                arm_ff <= 1'b1;
            end
            if (wake_ff) begin
                hold_ff <= `ATCS_HOLD_CYC;
            end else if (hold_ff != 3'h0) begin
                hold_ff <= hold_ff - 3'h1;
            end
        end
    end

    assign wake_req = wake_ff;
    assign cpu_hold = (hold_ff != 3'h0);
endmodule
